// >>> dms_pkg.sv
// Package for the driver mode sequencer: states, timing constants, register map.
// Assumes a single 100 MHz core clock; sequencing delays except EN_QUAL_CYC are overridable at the top, retry and deglitch counts are not.
package dms_pkg;
    localparam int CLK_MHZ = 100;
    localparam int NUM_FAULTS = 4;
    typedef enum logic [1:0] {
        DMS_SHUTDOWN = 2'b00,
        DMS_SLEEP = 2'b01,
        DMS_OPERATING = 2'b10,
        DMS_FAULT = 2'b11
    } dms_state_e;
    // Delay figures in microseconds; tenths of a microsecond for deglitch
    localparam int RETRY_LONG_US = 4000;
    localparam int RETRY_SHORT_US = 70;
    localparam int DEG_00_TENTHS = 14;
    localparam int DEG_01_TENTHS = 22;
    localparam int DEG_10_TENTHS = 32;
    localparam int DEG_11_TENTHS = 54;
    localparam int RETRY_LONG_CYC = RETRY_LONG_US * CLK_MHZ;
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_MHZ;
    localparam int DEG_00_CYC = DEG_00_TENTHS * CLK_MHZ / 10;
    localparam int DEG_01_CYC = DEG_01_TENTHS * CLK_MHZ / 10;
    localparam int DEG_10_CYC = DEG_10_TENTHS * CLK_MHZ / 10;
    localparam int DEG_11_CYC = DEG_11_TENTHS * CLK_MHZ / 10;
    localparam logic [1:0] DEG_STRAP_CODE = 2'h2;
    // Default sequencing delays in cycles
    localparam int STARTUP_CYC = 200;
    localparam int WAKE_CYC = 100;
    localparam int SLEEP_CYC = 100;
    localparam int RECOVER_CYC = 100;
    localparam int SHDN_CYC = 50;
    localparam int EN_QUAL_CYC = 8;
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_FAULT = 8'h14;
    // Configuration fields
    localparam int CFG_DEG_LSB = 0;
    localparam int CFG_SHUNT_RETRY_BIT = 2;
    localparam int CFG_DRAIN_RETRY_BIT = 3;
    localparam int CFG_RECOV_LSB = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RECOV_RESET = 8'hFF;
    // Interrupt bits
    localparam int IRQ_STATE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_OCP = 2;
    localparam int IRQ_BITS = 3;
endpackage

// >>> dms_ocp_channel.sv
// One overcurrent channel: deglitch filter then retry-delay blanking.
// Assumes the detector level is synchronous to core_clk.
`timescale 1ns/100ps
module dms_ocp_channel (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Timing selection
    input wire logic [1:0] degSel,
    input wire logic retryShort,
    // Detector and result
    input wire logic rawTrip,
    output logic tripped
);
    import dms_pkg::*;
    logic [9:0] degCnt_q;
    logic [19:0] retryCnt_q;
    logic [9:0] degLimit;
    logic [19:0] retryLimit;

    always_comb begin
        case (degSel)
            2'b00: degLimit = 10'(DEG_00_CYC);
            2'b01: degLimit = 10'(DEG_01_CYC);
            2'b10: degLimit = 10'(DEG_10_CYC);
            default: degLimit = 10'(DEG_11_CYC);
        endcase
        retryLimit = retryShort ? 20'(RETRY_SHORT_CYC) : 20'(RETRY_LONG_CYC);
    end

    // Detection must persist for the deglitch time before it counts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            degCnt_q <= 10'h000;
        end else if (!rawTrip) begin
            degCnt_q <= 10'h000;
        end else if (degCnt_q != degLimit) begin
            degCnt_q <= degCnt_q + 10'h001;
        end
    end

    // Fault held for the retry delay after the trip, then released if clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            retryCnt_q <= 20'h00000;
        end else if (rawTrip && degCnt_q == degLimit) begin
            retryCnt_q <= retryLimit;
        end else if (retryCnt_q != 20'h00000) begin
            retryCnt_q <= retryCnt_q - 20'h00001;
        end
    end

    assign tripped = (retryCnt_q != 20'h00000);

    property p_retry_hold;
        @(posedge core_clk) disable iff (rst)
        $rose(tripped) |-> tripped [*8];
    endproperty
    a_retry_hold: assert property (p_retry_hold) else $error("retry hold too short");

    property p_deglitch;
        @(posedge core_clk) disable iff (rst)
        $rose(tripped) |-> $past(rawTrip, 4);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("trip without deglitch");
endmodule

// >>> dms_sequencer.sv
// Top-level mode sequencer of a three-phase gate driver.
// Assumes inputs synchronous to core_clk except enable; por asserts when supply is low.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module dms_sequencer #(
    parameter int STARTUP_DLY = dms_pkg::STARTUP_CYC,
    parameter int WAKE_DLY = dms_pkg::WAKE_CYC,
    parameter int SLEEP_DLY = dms_pkg::SLEEP_CYC,
    parameter int RECOVER_DLY = dms_pkg::RECOVER_CYC,
    parameter int SHDN_DLY = dms_pkg::SHDN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Supply and host
    input wire logic supplyOk,
    input wire logic enablePin,
    input wire logic serialMode,
    // Fault detectors: drain ocp, shunt ocp, other faults
    input wire logic drainOcpRaw,
    input wire logic shuntOcpRaw,
    input wire logic [dms_pkg::NUM_FAULTS-1:0] otherFault,
    input wire logic [dms_pkg::NUM_FAULTS-1:0] faultRecoverable,
    // Per-source active-low disable requests for drive chain
    input wire logic [dms_pkg::NUM_FAULTS-1:0] faultDisable_n,
    // Phase control in and gate control out
    input wire logic [5:0] phaseIn,
    output logic [5:0] gateOut,
    // Regulators and drive chain
    output logic startupRegEn,
    output logic auxRegEn,
    output logic buckBoostEn,
    output logic chargePumpEn,
    output logic drivePathRegEn,
    // Host reporting
    output logic fault_report_n,
    output logic [1:0] modeState,
    output logic irq,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    import dms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Enable synchroniser and qualifier

    logic enMeta_q, enSync_q, enQual_q;
    logic [3:0] enCnt_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enMeta_q <= 1'b0;
            enSync_q <= 1'b0;
        end else begin
            enMeta_q <= enablePin;
            enSync_q <= enMeta_q;
        end
    end

    // Qualified level moves only after the synced level holds steady
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enCnt_q <= 4'h0;
            enQual_q <= 1'b0;
        end else if (enSync_q == enQual_q) begin
            enCnt_q <= 4'h0;
        end else if (enCnt_q == 4'(EN_QUAL_CYC - 1)) begin
            enCnt_q <= 4'h0;
            enQual_q <= enSync_q;
        end else begin
            enCnt_q <= enCnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register and overcurrent channels

    logic [7:0] cfg_q;
    logic [1:0] degSel;
    logic shuntShort, drainShort, drainTrip, shuntTrip;

    // Strap mode forces the fixed 3.2us deglitch and the long retry delay
    assign degSel = serialMode ? cfg_q[CFG_DEG_LSB +: 2] : DEG_STRAP_CODE;
    assign shuntShort = serialMode & cfg_q[CFG_SHUNT_RETRY_BIT];
    assign drainShort = serialMode & cfg_q[CFG_DRAIN_RETRY_BIT];

    dms_ocp_channel uDrain (
        .core_clk(core_clk),
        .rst(rst),
        .degSel(degSel),
        .retryShort(drainShort),
        .rawTrip(drainOcpRaw),
        .tripped(drainTrip)
    );

    dms_ocp_channel uShunt (
        .core_clk(core_clk),
        .rst(rst),
        .degSel(degSel),
        .retryShort(shuntShort),
        .rawTrip(shuntOcpRaw),
        .tripped(shuntTrip)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Fault aggregation

    logic anyFault, canRecover, chainAllow_n;
    logic [3:0] recovMask;

    assign recovMask = cfg_q[CFG_RECOV_LSB +: 4];
    assign anyFault = drainTrip | shuntTrip | (|otherFault);
    // Recovery needs no standing fault and every source marked recoverable or masked by the cfg recovery bits
    assign canRecover = !drainTrip && !shuntTrip && !(|otherFault) &&
                        (&(faultRecoverable | recovMask));
    // Active-low disables of all sources combine by AND
    assign chainAllow_n = &faultDisable_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode state machine

    dms_state_e state_q, state_d;
    logic [15:0] dly_q;
    logic [15:0] dlyLimit;
    logic dlyDone, pending;

    // Which delayed transition is pending in the current state
    always_comb begin
        pending = 1'b0;
        dlyLimit = 16'h0000;
        case (state_q)
            DMS_SHUTDOWN: begin
                pending = supplyOk;
                dlyLimit = 16'(STARTUP_DLY);
            end
            DMS_SLEEP: begin
                pending = !supplyOk || enQual_q;
                dlyLimit = !supplyOk ? 16'(SHDN_DLY) : 16'(WAKE_DLY);
            end
            DMS_OPERATING: begin
                pending = supplyOk && !anyFault && !enQual_q;
                dlyLimit = 16'(SLEEP_DLY);
            end
            DMS_FAULT: begin
                pending = !supplyOk || !enQual_q || canRecover;
                dlyLimit = !supplyOk ? 16'(SHDN_DLY) : 16'(RECOVER_DLY);
            end
            default: begin
                pending = 1'b0;
                dlyLimit = 16'h0000;
            end
        endcase
    end

    assign dlyDone = pending && (dly_q >= dlyLimit);

    always_comb begin
        state_d = state_q;
        case (state_q)
            DMS_SHUTDOWN: begin
                if (dlyDone) state_d = DMS_SLEEP;
            end
            DMS_SLEEP: begin
                if (dlyDone && !supplyOk) state_d = DMS_SHUTDOWN;
                else if (dlyDone) state_d = DMS_OPERATING;
            end
            DMS_OPERATING: begin
                if (!supplyOk) state_d = DMS_SHUTDOWN;
                else if (anyFault) state_d = DMS_FAULT;
                else if (dlyDone) state_d = DMS_SLEEP;
            end
            DMS_FAULT: begin
                if (dlyDone && !supplyOk) state_d = DMS_SHUTDOWN;
                else if (dlyDone && !enQual_q) state_d = DMS_SLEEP;
                else if (dlyDone) state_d = DMS_OPERATING;
            end
            default: state_d = DMS_SHUTDOWN;
        endcase
    end

    // Delay counter restarts whenever the pending reason lapses or the state moves
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dly_q <= 16'h0000;
        end else if (!pending || state_d != state_q) begin
            dly_q <= 16'h0000;
        end else if (dly_q != 16'hFFFF) begin
            dly_q <= dly_q + 16'h0001;
        end
    end

    // Reset is the power-on indication, so reset lands in shutdown
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= DMS_SHUTDOWN;
        end else if (!supplyOk && state_q == DMS_OPERATING) begin
            state_q <= DMS_SHUTDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs per state

    logic isOp, isFault, chainOn;
    assign isOp = (state_q == DMS_OPERATING);
    assign isFault = (state_q == DMS_FAULT);
    // In fault the chain stays up only if every source permits it
    assign chainOn = isOp || (isFault && chainAllow_n);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gateOut <= 6'h00;
            startupRegEn <= 1'b1;
            auxRegEn <= 1'b0;
            buckBoostEn <= 1'b0;
            chargePumpEn <= 1'b0;
            drivePathRegEn <= 1'b0;
            fault_report_n <= 1'b1;
        end else begin
            gateOut <= (isOp && !anyFault) ? phaseIn : 6'h00;
            startupRegEn <= !chainOn;
            auxRegEn <= (state_q != DMS_SHUTDOWN);
            buckBoostEn <= chainOn;
            chargePumpEn <= chainOn;
            drivePathRegEn <= chainOn;
            fault_report_n <= !isFault;
        end
    end

    assign modeState = state_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts and register port

    logic [IRQ_BITS-1:0] irqStat_q, irqEn_q, irqEvt;
    assign irqEvt[IRQ_STATE] = (state_d != state_q);
    assign irqEvt[IRQ_FAULT] = (state_d == DMS_FAULT) && !isFault;
    assign irqEvt[IRQ_OCP] = drainTrip | shuntTrip;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
            irqEn_q <= '0;
        end else if (regWr && regAddr == ADDR_CFG) begin
            cfg_q <= regWdata[7:0];
        end else if (regWr && regAddr == ADDR_IRQ_EN) begin
            irqEn_q <= regWdata[IRQ_BITS-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~((regWr && regAddr == ADDR_IRQ_CLR) ?
                          regWdata[IRQ_BITS-1:0] : '0)) | irqEvt;
        end
    end

    assign irq = |(irqStat_q & irqEn_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                ADDR_CFG: regRdata <= {24'h000000, cfg_q};
                ADDR_STATUS: regRdata <= {28'h0000000, enQual_q, isFault, state_q};
                ADDR_IRQ_STAT: regRdata <= {29'h0, irqStat_q};
                ADDR_IRQ_EN: regRdata <= {29'h0, irqEn_q};
                ADDR_FAULT: regRdata <= {24'h000000, otherFault, 2'b00, shuntTrip, drainTrip};
                default: regRdata <= 32'h00000000;
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    // Cycles the supply has stood high; judges the startup delay apart from dly_q
    logic [15:0] supHigh_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            supHigh_q <= 16'h0000;
        end else if (!supplyOk) begin
            supHigh_q <= 16'h0000;
        end else if (supHigh_q != 16'hFFFF) begin
            supHigh_q <= supHigh_q + 16'h0001;
        end
    end

    property p_shutdown_low;
        @(posedge core_clk) disable iff (rst)
        !supplyOk && state_q == DMS_OPERATING |=> state_q == DMS_SHUTDOWN;
    endproperty
    a_shutdown_low: assert property (p_shutdown_low) else $error("no shutdown");

    property p_sleep_gates;
        @(posedge core_clk) disable iff (rst)
        state_q == DMS_SLEEP |=> gateOut == 6'h00;
    endproperty
    a_sleep_gates: assert property (p_sleep_gates) else $error("gates on in sleep");

    property p_sleep_regs;
        @(posedge core_clk) disable iff (rst)
        state_q == DMS_SLEEP && $past(state_q) == DMS_SLEEP |->
            startupRegEn && auxRegEn && !buckBoostEn && !chargePumpEn;
    endproperty
    a_sleep_regs: assert property (p_sleep_regs) else $error("sleep regs wrong");

    property p_op_regs;
        @(posedge core_clk) disable iff (rst)
        state_q == DMS_OPERATING |=> !startupRegEn && drivePathRegEn;
    endproperty
    a_op_regs: assert property (p_op_regs) else $error("operating regs wrong");

    property p_fault_pin;
        @(posedge core_clk) disable iff (rst)
        state_q == DMS_FAULT |=> !fault_report_n;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin idle");

    property p_fault_entry;
        @(posedge core_clk) disable iff (rst)
        state_q == DMS_OPERATING && supplyOk && anyFault |=> state_q == DMS_FAULT;
    endproperty
    a_fault_entry: assert property (p_fault_entry) else $error("fault not entered");

    property p_startup_delay;
        @(posedge core_clk) disable iff (rst)
        $past(state_q) == DMS_SHUTDOWN && state_q == DMS_SLEEP |->
            supHigh_q > 16'(STARTUP_DLY);
    endproperty
    a_startup_delay: assert property (p_startup_delay) else $error("startup early");

    property p_en_glitch;
        @(posedge core_clk) disable iff (rst)
        $changed(enQual_q) |-> $past(enSync_q, 4) == enQual_q;
    endproperty
    a_en_glitch: assert property (p_en_glitch) else $error("enable unqualified");

    c_wake: cover property (@(posedge core_clk) disable iff (rst)
        state_q == DMS_SLEEP ##1 state_q == DMS_OPERATING);
    c_fault: cover property (@(posedge core_clk) disable iff (rst)
        state_q == DMS_OPERATING ##1 state_q == DMS_FAULT);
    c_recover: cover property (@(posedge core_clk) disable iff (rst)
        state_q == DMS_FAULT ##1 state_q == DMS_OPERATING);
endmodule

// >>> dms_host_model.sv
// Host model: holds the enable pin and watches the fault pin.
// Assumes the sequencer samples enable on rising edges of core_clk.
`timescale 1ns/100ps
module dms_host_model (
    // Clock
    input wire logic core_clk,
    // Bench command
    input wire logic wantEnable,
    // Device pins
    input wire logic fault_report_n,
    output logic enablePin,
    output logic faultSeen
);
    logic [3:0] glitchCnt;
    initial begin
        enablePin = 1'b0;
        glitchCnt = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Enable is held steady; it only glitches when the bench asks for it
    always @(posedge core_clk) begin
        if (glitchCnt != 4'h0) begin
            glitchCnt <= glitchCnt - 4'h1;
            enablePin <= ~wantEnable;
        end else begin
            enablePin <= wantEnable;
        end
    end
    task automatic glitch(input logic [3:0] len);
        glitchCnt <= len;
    endtask
    assign faultSeen = (fault_report_n === 1'b0);
endmodule

// >>> testbench.sv
// Self-checking bench for the driver mode sequencer.
// Assumes short sequencing delays; drain detector is driven only in the overcurrent test.
`timescale 1ns/100ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
    import dms_pkg::*;
    localparam int ST = 6;
    localparam int WK = 4;
    localparam int SL = 4;
    localparam int RC = 4;
    localparam int SD = 3;
    logic core_clk, rst, supplyOk, serialMode, drainOcpRaw, shuntOcpRaw;
    logic wantEnable, enablePin, faultSeen, regWr, regRd, irq, fault_report_n;
    logic startupRegEn, auxRegEn, buckBoostEn, chargePumpEn, drivePathRegEn;
    logic [3:0] otherFault, faultRecoverable, faultDisable_n;
    logic [5:0] phaseIn, gateOut;
    logic [1:0] modeState;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rd;
    int fails, testsRun, n;
    ////////////////////////////////////////////////////////////////////////
    dms_sequencer #(.STARTUP_DLY(ST), .WAKE_DLY(WK), .SLEEP_DLY(SL),
        .RECOVER_DLY(RC), .SHDN_DLY(SD)) u_dms_sequencer (.core_clk(core_clk),
        .rst(rst), .supplyOk(supplyOk), .enablePin(enablePin), .serialMode(serialMode),
        .drainOcpRaw(drainOcpRaw), .shuntOcpRaw(shuntOcpRaw), .otherFault(otherFault),
        .faultRecoverable(faultRecoverable), .faultDisable_n(faultDisable_n),
        .phaseIn(phaseIn), .gateOut(gateOut), .startupRegEn(startupRegEn),
        .auxRegEn(auxRegEn), .buckBoostEn(buckBoostEn), .chargePumpEn(chargePumpEn),
        .drivePathRegEn(drivePathRegEn), .fault_report_n(fault_report_n),
        .modeState(modeState), .irq(irq), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    dms_host_model u_dms_host_model (.core_clk(core_clk), .wantEnable(wantEnable),
        .fault_report_n(fault_report_n), .enablePin(enablePin), .faultSeen(faultSeen));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_mode(input logic [1:0] m, input int bound);
        for (n = 0; n < bound; n++) begin
            @(posedge core_clk);
            #1;
            if (modeState === m) break;
        end
        if (modeState !== m) begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, modeState, m);
            give_verdict;
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_power;
        `CHK(modeState, DMS_SHUTDOWN)
        `CHK({startupRegEn, buckBoostEn, fault_report_n, irq}, 4'hA)
        @(posedge core_clk);
        phaseIn <= 6'h2A;
        supplyOk <= 1'b1;
        wait_mode(DMS_SLEEP, 40);
        `CHK(n >= ST, 1'b1)
        settle(1);
        `CHK({startupRegEn, auxRegEn, buckBoostEn, chargePumpEn, drivePathRegEn}, 5'h18)
        `CHK(gateOut, 6'h00)
        u_dms_host_model.glitch(4'h4);
        settle(20);
        `CHK(modeState, DMS_SLEEP)
        reg_rd(ADDR_STATUS);
        `CHK(rd, 32'h1)
        $display("test power and glitch done");
    endtask
    task automatic t_wake;
        @(posedge core_clk);
        wantEnable <= 1'b1;
        wait_mode(DMS_OPERATING, 60);
        `CHK(n >= WK + EN_QUAL_CYC, 1'b1)
        settle(1);
        `CHK({startupRegEn, buckBoostEn, chargePumpEn, drivePathRegEn}, 4'h7)
        phaseIn <= 6'h15;
        settle(2);
        `CHK(gateOut, 6'h15)
        $display("test wake done");
    endtask
    task automatic t_fault;
        reg_wr(ADDR_IRQ_EN, 32'h2);
        @(posedge core_clk);
        faultDisable_n <= 4'hE;
        otherFault <= 4'h1;
        wait_mode(DMS_FAULT, 10);
        settle(1);
        `CHK({fault_report_n, faultSeen, gateOut, irq}, 9'h081)
        reg_rd(ADDR_FAULT);
        `CHK(rd, 32'h10)
        reg_rd(ADDR_STATUS);
        `CHK(rd, 32'hF)
        otherFault <= 4'h3;
        settle(RC + 4);
        `CHK({modeState, buckBoostEn}, 3'h6)
        faultDisable_n <= 4'hF;
        settle(3);
        `CHK(buckBoostEn, 1'b1)
        reg_wr(ADDR_IRQ_CLR, 32'h2);
        settle(2);
        `CHK(irq, 1'b0)
        reg_rd(8'h20);
        `CHK(rd, 32'h0)
        faultRecoverable <= 4'hF;
        otherFault <= 4'h0;
        wait_mode(DMS_OPERATING, 30);
        `CHK(n >= RC, 1'b1)
        $display("test fault done");
    endtask
    task automatic t_sleep;
        @(posedge core_clk);
        otherFault <= 4'h4;
        wait_mode(DMS_FAULT, 10);
        wantEnable <= 1'b0;
        wait_mode(DMS_SLEEP, 40);
        `CHK(n >= RC, 1'b1)
        settle(1);
        `CHK({startupRegEn, auxRegEn, buckBoostEn}, 3'h6)
        otherFault <= 4'h0;
        wantEnable <= 1'b1;
        wait_mode(DMS_OPERATING, 60);
        wantEnable <= 1'b0;
        wait_mode(DMS_SLEEP, 60);
        `CHK(n >= SL + EN_QUAL_CYC, 1'b1)
        $display("test sleep done");
    endtask
    task automatic t_ocp;
        serialMode <= 1'b1;
        reg_wr(ADDR_CFG, 32'h4);
        wantEnable <= 1'b1;
        wait_mode(DMS_OPERATING, 60);
        shuntOcpRaw <= 1'b1;
        settle(DEG_00_CYC - 15);
        `CHK(modeState, DMS_OPERATING)
        wait_mode(DMS_FAULT, 40);
        shuntOcpRaw <= 1'b0;
        reg_rd(ADDR_FAULT);
        `CHK(rd, 32'h2)
        settle(RETRY_SHORT_CYC - 300);
        `CHK(modeState, DMS_FAULT)
        wait_mode(DMS_OPERATING, 600);
        // Drain channel: longest deglitch code and short retry
        reg_wr(ADDR_CFG, 32'hB);
        drainOcpRaw <= 1'b1;
        settle(DEG_11_CYC - 15);
        `CHK(modeState, DMS_OPERATING)
        wait_mode(DMS_FAULT, 40);
        drainOcpRaw <= 1'b0;
        reg_rd(ADDR_FAULT);
        `CHK(rd, 32'h1)
        settle(RETRY_SHORT_CYC - 300);
        `CHK(modeState, DMS_FAULT)
        wait_mode(DMS_OPERATING, 600);
        $display("test overcurrent done");
    endtask
    task automatic t_down;
        supplyOk <= 1'b0;
        wait_mode(DMS_SHUTDOWN, 3);
        settle(1);
        `CHK({startupRegEn, buckBoostEn, gateOut}, 8'h80)
        wantEnable <= 1'b0;
        supplyOk <= 1'b1;
        wait_mode(DMS_SLEEP, 40);
        supplyOk <= 1'b0;
        wait_mode(DMS_SHUTDOWN, 20);
        `CHK(n >= SD, 1'b1)
        $display("test shutdown done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        supplyOk = 1'b0;
        serialMode = 1'b0;
        drainOcpRaw = 1'b0;
        shuntOcpRaw = 1'b0;
        wantEnable = 1'b0;
        otherFault = 4'h0;
        faultRecoverable = 4'h0;
        faultDisable_n = 4'hF;
        phaseIn = 6'h00;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        fails = 0;
        testsRun = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        settle(1);
        t_power;
        t_wake;
        t_fault;
        t_sleep;
        t_ocp;
        t_down;
        give_verdict;
    end
endmodule
